// ===== inc/azd_cfg.svh
// Constants of the zero-detect flag block
// Notes on behaviour
// - Left and right zero detection run fully apart from each other.
// - A channel is zero-detected after 1024 consecutive zero samples.
// - A zero-detected channel drives its own flag pin to 1 by default.
// - Setting the polarity-invert bit inverts the flag pins' active level.
// - Polarity-invert bit is 0 after reset: flags active high.
// - Setting the merge bit gives one common flag for both channels.
// - Merge bit is 0 after reset: independent left and right flags.
// - Zero mute is off at reset; output stays connected on all-zero input.
// - In merged mode the common flag uses the right pin; left pin unassigned.
// - Inverted polarity: flag pins low during zero detect, high otherwise.
`ifndef AZD_CFG_SVH
`define AZD_CFG_SVH

`define AZD_ADDR_W 8
`define AZD_SAMPLE_W 24
`define AZD_RUN_W 11
`define AZD_EVT_W 4
`define AZD_ZERO_RUN 11'h400

`define AZD_OFS_CFG 8'h00
`define AZD_OFS_STATUS 8'h04
`define AZD_OFS_EVT 8'h08
`define AZD_OFS_MASK 8'h0c
`define AZD_OFS_RUN 8'h10

`define AZD_CFG_INV_BIT 1
`define AZD_CFG_MERGE_BIT 2
`define AZD_CFG_MUTE_BIT 3
`define AZD_CFG_RESET 3'h0
`define AZD_MASK_RESET 4'h0

`define AZD_RESP_OKAY 2'h0
`define AZD_RESP_SLVERR 2'h2

`endif

// ===== inc/azd_pkg.sv
// Types of the zero-detect flag block
package azd_pkg;

	typedef struct packed {
		logic left;
		logic right;
	} azd_pair_t;

	typedef struct packed {
		logic mute_en;
		logic merge;
		logic invert;
	} azd_cfg_t;

	typedef struct packed {
		logic right_exit;
		logic left_exit;
		logic right_enter;
		logic left_enter;
	} azd_evt_t;

endpackage

// ===== logic/azd_frame_tick.sv
// Frame clock rising edge to one-cycle tick
`timescale 1ns/100ps
`default_nettype none
module azd_frame_tick (
	// Clock and reset
	input  wire logic core_clk_i,
	input  wire logic arst_n_i,
	// Frame clock and tick
	input  wire logic frame_clock_i,
	output logic      tick_o
);
	logic prev_r;

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			prev_r <= 1'b0;
		end else begin
			prev_r <= frame_clock_i;
		end
	end

	assign tick_o = frame_clock_i & ~prev_r;
endmodule // azd_frame_tick
`default_nettype wire

// ===== logic/azd_top.sv
// Zero-detect flags with AXI4-Lite control and interrupt
`timescale 1ns/100ps
`default_nettype none
`include "azd_cfg.svh"
module azd_top (
	// Clock and reset
	input  wire logic                     core_clk_i,
	input  wire logic                     arst_n_i,
	// Audio frame and samples
	input  wire logic                     frame_clock_i,
	input  wire logic [`AZD_SAMPLE_W-1:0] left_sample_i,
	input  wire logic [`AZD_SAMPLE_W-1:0] right_sample_i,
	// Flag pins
	output logic                          left_zero_flag_o,
	output logic                          right_zero_flag_o,
	// Mute controls towards the output stage
	output logic                          left_mute_o,
	output logic                          right_mute_o,
	// Interrupt
	output logic                          irq_o,
	// AXI4-Lite write address
	input  wire logic [`AZD_ADDR_W-1:0]   s_axi_awaddr_i,
	input  wire logic                     s_axi_awvalid_i,
	output logic                          s_axi_awready_o,
	// AXI4-Lite write data
	input  wire logic [31:0]              s_axi_wdata_i,
	input  wire logic [3:0]               s_axi_wstrb_i,
	input  wire logic                     s_axi_wvalid_i,
	output logic                          s_axi_wready_o,
	// AXI4-Lite write response
	output logic [1:0]                    s_axi_bresp_o,
	output logic                          s_axi_bvalid_o,
	input  wire logic                     s_axi_bready_i,
	// AXI4-Lite read address
	input  wire logic [`AZD_ADDR_W-1:0]   s_axi_araddr_i,
	input  wire logic                     s_axi_arvalid_i,
	output logic                          s_axi_arready_o,
	// AXI4-Lite read data
	output logic [31:0]                   s_axi_rdata_o,
	output logic [1:0]                    s_axi_rresp_o,
	output logic                          s_axi_rvalid_o,
	input  wire logic                     s_axi_rready_i
);

	function automatic logic addr_hit(
		input logic [`AZD_ADDR_W-1:0] addr,
		input logic [`AZD_ADDR_W-1:0] ofs
	);
		addr_hit = (addr[`AZD_ADDR_W-1:2] == ofs[`AZD_ADDR_W-1:2]);
	endfunction

	function automatic logic addr_mapped(
		input logic [`AZD_ADDR_W-1:0] addr
	);
		addr_mapped = addr_hit(addr, `AZD_OFS_CFG)
			| addr_hit(addr, `AZD_OFS_STATUS)
			| addr_hit(addr, `AZD_OFS_EVT)
			| addr_hit(addr, `AZD_OFS_MASK)
			| addr_hit(addr, `AZD_OFS_RUN);
	endfunction

	// Shared by both flag pins so their polarity can never drift apart
	function automatic logic pin_level(
		input logic raw,
		input logic invert
	);
		pin_level = raw ^ invert;
	endfunction

	// Frame tick and per-channel detectors
	wire                   frame_tick;
	wire [`AZD_RUN_W-1:0]  run_left;
	wire [`AZD_RUN_W-1:0]  run_right;
	azd_pkg::azd_pair_t    det;

	azd_frame_tick u_tick (
		.core_clk_i    (core_clk_i),
		.arst_n_i      (arst_n_i),
		.frame_clock_i (frame_clock_i),
		.tick_o        (frame_tick)
	);

	// Separate instances share nothing but clock, reset and the frame tick
	azd_zero_run u_run_left (
		.core_clk_i (core_clk_i),
		.arst_n_i   (arst_n_i),
		.tick_i     (frame_tick),
		.sample_i   (left_sample_i),
		.run_o      (run_left),
		.detect_o   (det.left)
	);

	azd_zero_run u_run_right (
		.core_clk_i (core_clk_i),
		.arst_n_i   (arst_n_i),
		.tick_i     (frame_tick),
		.sample_i   (right_sample_i),
		.run_o      (run_right),
		.detect_o   (det.right)
	);

	// Control state
	azd_pkg::azd_cfg_t     cfg_r;
	azd_pkg::azd_cfg_t     cfg_nxt;
	azd_pkg::azd_evt_t     evt_r;
	azd_pkg::azd_evt_t     evt_nxt;
	azd_pkg::azd_evt_t     evt_set;
	azd_pkg::azd_pair_t    det_prev_r;
	logic [`AZD_EVT_W-1:0] mask_r;
	logic [`AZD_EVT_W-1:0] mask_nxt;
	logic [`AZD_EVT_W-1:0] evt_clr;

	// Bus state
	logic                   awready_r;
	logic                   wready_r;
	logic                   arready_r;
	logic                   aw_full_r;
	logic                   w_full_r;
	logic [`AZD_ADDR_W-1:0] awaddr_r;
	logic [31:0]            wdata_r;
	logic [3:0]             wstrb_r;
	logic                   bvalid_r;
	logic [1:0]             bresp_r;
	logic                   rvalid_r;
	logic [1:0]             rresp_r;
	logic [31:0]            rdata_r;

	// Pin state
	logic                   left_flag_r;
	logic                   right_flag_r;
	logic                   left_mute_r;
	logic                   right_mute_r;
	logic                   irq_r;

	// Handshakes
	wire aw_hs;
	wire w_hs;
	wire ar_hs;
	wire wr_fire;
	wire aw_full_nxt;
	wire w_full_nxt;
	wire bvalid_nxt;
	wire rvalid_nxt;

	assign aw_hs   = s_axi_awvalid_i & awready_r;
	assign w_hs    = s_axi_wvalid_i & wready_r;
	assign ar_hs   = s_axi_arvalid_i & arready_r;
	// Address and data may arrive in either order; commit once both are held
	assign wr_fire = aw_full_r & w_full_r & ~bvalid_r;

	assign aw_full_nxt = (aw_full_r | aw_hs) & ~wr_fire;
	assign w_full_nxt  = (w_full_r | w_hs) & ~wr_fire;
	assign bvalid_nxt  = wr_fire | (bvalid_r & ~s_axi_bready_i);
	assign rvalid_nxt  = ar_hs | (rvalid_r & ~s_axi_rready_i);

	// Write decode; all fields live in byte lane 0
	wire wr_lane0;
	wire wr_cfg;
	wire wr_evt;
	wire wr_mask;

	assign wr_lane0 = wr_fire & wstrb_r[0];
	assign wr_cfg   = wr_lane0 & addr_hit(awaddr_r, `AZD_OFS_CFG);
	assign wr_evt   = wr_lane0 & addr_hit(awaddr_r, `AZD_OFS_EVT);
	assign wr_mask  = wr_lane0 & addr_hit(awaddr_r, `AZD_OFS_MASK);

	assign cfg_nxt.invert  = wr_cfg ? wdata_r[`AZD_CFG_INV_BIT] : cfg_r.invert;
	assign cfg_nxt.merge   = wr_cfg ? wdata_r[`AZD_CFG_MERGE_BIT] : cfg_r.merge;
	assign cfg_nxt.mute_en = wr_cfg ? wdata_r[`AZD_CFG_MUTE_BIT] : cfg_r.mute_en;
	assign mask_nxt = wr_mask ? wdata_r[`AZD_EVT_W-1:0] : mask_r;

	// Events: entering and leaving zero detect, per channel
	assign evt_set.left_enter  = det.left & ~det_prev_r.left;
	assign evt_set.right_enter = det.right & ~det_prev_r.right;
	assign evt_set.left_exit   = ~det.left & det_prev_r.left;
	assign evt_set.right_exit  = ~det.right & det_prev_r.right;

	// Set beats a simultaneous write-one clear
	assign evt_clr = wr_evt ? wdata_r[`AZD_EVT_W-1:0] : '0;
	assign evt_nxt = (evt_r & ~evt_clr) | evt_set;

	// Flag pin levels
	wire common_zero;
	wire right_raw;
	wire left_raw;
	wire right_pin_nxt;
	wire left_pin_nxt;

	assign common_zero = det.left & det.right;
	assign right_raw   = cfg_r.merge ? common_zero : det.right;
	// Unassigned left pin in merged mode sits at its inactive level
	assign left_raw    = cfg_r.merge ? 1'b0 : det.left;
	assign right_pin_nxt = pin_level(right_raw, cfg_r.invert);
	assign left_pin_nxt  = pin_level(left_raw, cfg_r.invert);

	// Read decode
	wire        rd_mapped;
	wire        rd_hit_cfg;
	wire        rd_hit_status;
	wire        rd_hit_evt;
	wire        rd_hit_mask;
	wire        rd_hit_run;
	wire [31:0] rd_status;
	wire [31:0] rd_run;
	logic [31:0] rd_data;

	assign rd_mapped     = addr_mapped(s_axi_araddr_i);
	assign rd_hit_cfg    = addr_hit(s_axi_araddr_i, `AZD_OFS_CFG);
	assign rd_hit_status = addr_hit(s_axi_araddr_i, `AZD_OFS_STATUS);
	assign rd_hit_evt    = addr_hit(s_axi_araddr_i, `AZD_OFS_EVT);
	assign rd_hit_mask   = addr_hit(s_axi_araddr_i, `AZD_OFS_MASK);
	assign rd_hit_run    = addr_hit(s_axi_araddr_i, `AZD_OFS_RUN);
	assign rd_status     = {29'h0, common_zero, det.right, det.left};
	assign rd_run        = {5'h00, run_right, 5'h00, run_left};

	always_comb begin
		rd_data = 32'h0;
		if (rd_hit_cfg) begin
			rd_data[`AZD_CFG_INV_BIT]   = cfg_r.invert;
			rd_data[`AZD_CFG_MERGE_BIT] = cfg_r.merge;
			rd_data[`AZD_CFG_MUTE_BIT]  = cfg_r.mute_en;
		end else if (rd_hit_status) begin
			rd_data = rd_status;
		end else if (rd_hit_evt) begin
			rd_data[`AZD_EVT_W-1:0] = evt_r;
		end else if (rd_hit_mask) begin
			rd_data[`AZD_EVT_W-1:0] = mask_r;
		end else if (rd_hit_run) begin
			rd_data = rd_run;
		end
	end

	// Write channel handshake state
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			aw_full_r <= 1'b0;
			w_full_r  <= 1'b0;
			awready_r <= 1'b0;
			wready_r  <= 1'b0;
			bvalid_r  <= 1'b0;
		end else begin
			aw_full_r <= aw_full_nxt;
			w_full_r  <= w_full_nxt;
			awready_r <= ~aw_full_nxt;
			wready_r  <= ~w_full_nxt;
			bvalid_r  <= bvalid_nxt;
		end
	end

	// Read channel handshake state
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			arready_r <= 1'b0;
			rvalid_r  <= 1'b0;
		end else begin
			arready_r <= ~rvalid_nxt;
			rvalid_r  <= rvalid_nxt;
		end
	end

	// Write payload, held until the commit
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			awaddr_r <= '0;
			wdata_r  <= 32'h0;
			wstrb_r  <= 4'h0;
			bresp_r  <= `AZD_RESP_OKAY;
		end else begin
			if (aw_hs) begin
				awaddr_r <= s_axi_awaddr_i;
			end
			if (w_hs) begin
				wdata_r <= s_axi_wdata_i;
				wstrb_r <= s_axi_wstrb_i;
			end
			if (wr_fire) begin
				bresp_r <= addr_mapped(awaddr_r) ? `AZD_RESP_OKAY : `AZD_RESP_SLVERR;
			end
		end
	end

	// Read payload, captured with the address
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rresp_r <= `AZD_RESP_OKAY;
			rdata_r <= 32'h0;
		end else begin
			if (ar_hs) begin
				rdata_r <= rd_data;
				rresp_r <= rd_mapped ? `AZD_RESP_OKAY : `AZD_RESP_SLVERR;
			end
		end
	end

	// Software-visible control
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cfg_r  <= `AZD_CFG_RESET;
			mask_r <= `AZD_MASK_RESET;
		end else begin
			cfg_r  <= cfg_nxt;
			mask_r <= mask_nxt;
		end
	end

	// Sticky events and the detect history they are edged against
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			evt_r      <= '0;
			det_prev_r <= '0;
		end else begin
			evt_r      <= evt_nxt;
			det_prev_r <= det;
		end
	end

	// Registered flag pins
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			left_flag_r  <= 1'b0;
			right_flag_r <= 1'b0;
		end else begin
			left_flag_r  <= left_pin_nxt;
			right_flag_r <= right_pin_nxt;
		end
	end

	// Registered mute and interrupt pins
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			left_mute_r  <= 1'b0;
			right_mute_r <= 1'b0;
			irq_r        <= 1'b0;
		end else begin
			// Mute only when enabled, so idle-channel noise stays observable
			left_mute_r  <= cfg_r.mute_en & det.left;
			right_mute_r <= cfg_r.mute_en & det.right;
			irq_r        <= |(evt_r & mask_r);
		end
	end

	assign left_zero_flag_o  = left_flag_r;
	assign right_zero_flag_o = right_flag_r;
	assign left_mute_o       = left_mute_r;
	assign right_mute_o      = right_mute_r;
	assign irq_o             = irq_r;

	assign s_axi_awready_o = awready_r;
	assign s_axi_wready_o  = wready_r;
	assign s_axi_bvalid_o  = bvalid_r;
	assign s_axi_bresp_o   = bresp_r;
	assign s_axi_arready_o = arready_r;
	assign s_axi_rvalid_o  = rvalid_r;
	assign s_axi_rresp_o   = rresp_r;
	assign s_axi_rdata_o   = rdata_r;

endmodule // azd_top
`default_nettype wire

// ===== logic/azd_zero_run.sv
// Zero-run counter and detector for one channel
`timescale 1ns/100ps
`default_nettype none
`include "azd_cfg.svh"
module azd_zero_run (
	// Clock and reset
	input  wire logic                     core_clk_i,
	input  wire logic                     arst_n_i,
	// Sample stream
	input  wire logic                     tick_i,
	input  wire logic [`AZD_SAMPLE_W-1:0] sample_i,
	// Result
	output logic      [`AZD_RUN_W-1:0]    run_o,
	output logic                          detect_o
);
	logic [`AZD_RUN_W-1:0] run_r;
	logic [`AZD_RUN_W-1:0] run_nxt;
	wire                   at_limit;

	assign at_limit = (run_r == `AZD_ZERO_RUN);
	// Saturate so a long silence cannot wrap back to zero
	assign run_nxt = (sample_i != '0) ? '0 :
		(at_limit ? run_r : run_r + 11'h001);

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			run_r <= '0;
		end else if (tick_i) begin
			run_r <= run_nxt;
		end
	end

	assign run_o    = run_r;
	assign detect_o = at_limit;
endmodule // azd_zero_run
`default_nettype wire

// ===== sim/azd_chk.sv
// Assertion checker for the zero-detect flag block
`timescale 1ns/100ps
`default_nettype none
`include "azd_cfg.svh"
module azd_chk (
	// Clock and reset
	input wire logic                     core_clk_i,
	input wire logic                     arst_n_i,
	// Audio side and pins
	input wire logic                     frame_clock_i,
	input wire logic [`AZD_SAMPLE_W-1:0] left_sample_i,
	input wire logic [`AZD_SAMPLE_W-1:0] right_sample_i,
	input wire logic                     left_zero_flag_o,
	input wire logic                     right_zero_flag_o,
	input wire logic                     left_mute_o,
	input wire logic                     right_mute_o,
	input wire logic                     irq_o,
	// Register writes
	input wire logic [`AZD_ADDR_W-1:0]   s_axi_awaddr_i,
	input wire logic                     s_axi_awvalid_i,
	input wire logic                     s_axi_awready_o,
	input wire logic [31:0]              s_axi_wdata_i,
	input wire logic [3:0]               s_axi_wstrb_i,
	input wire logic                     s_axi_wvalid_i,
	input wire logic                     s_axi_wready_o
);
	logic                  fc_r;
	logic [`AZD_RUN_W-1:0] zl_r;
	logic [`AZD_RUN_W-1:0] zr_r;
	logic [3:0]            sc_r;
	azd_pkg::azd_cfg_t     cfg_r;
	wire tk = frame_clock_i & ~fc_r;
	wire dl = zl_r == `AZD_ZERO_RUN;
	wire dr = zr_r == `AZD_ZERO_RUN;
	wire ok = sc_r > 4'h3;
	wire el = cfg_r.merge ? cfg_r.invert : dl ^ cfg_r.invert;
	wire er = (cfg_r.merge ? dl & dr : dr) ^ cfg_r.invert;
	// Snoop only works when address and data are taken at one edge
	wire cw = s_axi_awvalid_i & s_axi_awready_o & s_axi_wvalid_i & s_axi_wready_o
		& (s_axi_awaddr_i == `AZD_OFS_CFG) & s_axi_wstrb_i[0];
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			fc_r  <= 1'h0;
			zl_r  <= '0;
			zr_r  <= '0;
			sc_r  <= 4'hf;
			cfg_r <= '0;
		end else begin
			fc_r <= frame_clock_i;
			if (tk)
				zl_r <= (|left_sample_i) ? '0 : zl_r + {10'h0, ~dl};
			if (tk)
				zr_r <= (|right_sample_i) ? '0 : zr_r + {10'h0, ~dr};
			sc_r <= cw ? 4'h0 : sc_r + {3'h0, ~&sc_r};
			if (cw)
				cfg_r <= s_axi_wdata_i[3:1];
		end
	end
	default clocking dc @(posedge core_clk_i); endclocking
	default disable iff (!arst_n_i);
	AST_LEFT_FLAG: assert property (tk && ok |-> left_zero_flag_o == el)
		else $error("left flag level wrong");
	AST_RIGHT_FLAG: assert property (tk && ok |-> right_zero_flag_o == er)
		else $error("right flag level wrong");
	AST_MERGE_LEFT: assert property (tk && ok && cfg_r.merge |-> left_zero_flag_o == cfg_r.invert)
		else $error("left pin not idle in merged mode");
	AST_INV_ACTIVE: assert property (tk && ok && cfg_r.invert && !cfg_r.merge && dr |-> !right_zero_flag_o)
		else $error("inverted flag not low on detect");
	AST_LEFT_MUTE: assert property (tk && ok |-> left_mute_o == (cfg_r.mute_en & dl))
		else $error("left mute wrong");
	AST_RIGHT_MUTE: assert property (tk && ok |-> right_mute_o == (cfg_r.mute_en & dr))
		else $error("right mute wrong");
	AST_LEFT_CLEAR: assert property (tk && ok && (|left_sample_i) |-> ##3 (sc_r < 4'h3 || left_zero_flag_o == cfg_r.invert))
		else $error("left flag not cleared by nonzero sample");
	AST_RESET_IDLE: assert property ($past(arst_n_i) == 1'h0 |-> !left_zero_flag_o && !right_zero_flag_o && !irq_o)
		else $error("outputs not idle after reset");
endmodule // azd_chk
bind azd_top azd_chk azd_chk_inst (.core_clk_i, .arst_n_i, .frame_clock_i, .left_sample_i, .right_sample_i,
	.left_zero_flag_o, .right_zero_flag_o, .left_mute_o, .right_mute_o, .irq_o, .s_axi_awaddr_i,
	.s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o);
`default_nettype wire

// ===== sim/azd_frame_src.sv
// Frame clock and sample source facing the block's audio input
`timescale 1ns/100ps
`default_nettype none
module azd_frame_src (
	// Clock and reset
	input  wire logic        core_clk_i,
	input  wire logic        arst_n_i,
	// Next samples from the bench
	input  wire logic [23:0] left_next_i,
	input  wire logic [23:0] right_next_i,
	// Frame outputs
	output logic             frame_clock_o,
	output logic             frame_start_o,
	output logic [23:0]      left_sample_o,
	output logic [23:0]      right_sample_o
);
	logic [2:0] cnt_r;
	assign frame_clock_o = cnt_r[2];
	assign frame_start_o = cnt_r == 3'h0;
	// Samples change mid low phase, steady around the rising edge
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cnt_r          <= 3'h0;
			left_sample_o  <= 24'h5a5a5a;
			right_sample_o <= 24'ha5a5a5;
		end else begin
			cnt_r <= cnt_r + 3'h1;
			if (cnt_r == 3'h2) begin
				left_sample_o  <= left_next_i;
				right_sample_o <= right_next_i;
			end
		end
	end
endmodule // azd_frame_src
`default_nettype wire

// ===== sim/azd_top_tb.sv
// Self-checking bench for the zero-detect flag block
`timescale 1ns/100ps
`default_nettype none
`include "azd_cfg.svh"
module azd_top_tb;
	logic        core_clk_i, arst_n_i, frame_clock_i, frame_start, fc_q;
	logic [23:0] left_sample_i, right_sample_i, left_next, right_next;
	logic        left_zero_flag_o, right_zero_flag_o, left_mute_o, right_mute_o, irq_o;
	logic [7:0]  s_axi_awaddr_i, s_axi_araddr_i;
	logic [31:0] s_axi_wdata_i, s_axi_rdata_o;
	logic [3:0]  s_axi_wstrb_i, cfg;
	logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
	logic        s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o, s_axi_bvalid_o, s_axi_bready_i;
	logic        s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o, s_axi_rready_i;
	int          fails, n_tests, zl, zr;
	integer      seed;
	azd_frame_src azd_frame_src_inst (.core_clk_i, .arst_n_i, .left_next_i(left_next), .right_next_i(right_next),
		.frame_clock_o(frame_clock_i), .frame_start_o(frame_start), .left_sample_o(left_sample_i),
		.right_sample_o(right_sample_i));
	azd_top azd_top_inst (.*);
	initial begin
		core_clk_i = 1'h0;
		forever #2.5 core_clk_i = ~core_clk_i;
	end
	// Zero-run reference, advanced on each frame rising edge
	always @(posedge core_clk_i) begin
		fc_q <= frame_clock_i;
		if (frame_clock_i && !fc_q) begin
			zl = (left_sample_i != 24'h0) ? 0 : (zl < 1024 ? zl + 1 : 1024);
			zr = (right_sample_i != 24'h0) ? 0 : (zr < 1024 ? zr + 1 : 1024);
		end
	end
	function automatic logic [3:0] pins(input logic [3:0] c, input logic l, input logic r);
		pins = {c[2] ? c[1] : l ^ c[1], (c[2] ? l & r : r) ^ c[1], c[3] & l, c[3] & r};
	endfunction
	function automatic logic [23:0] nz();
		nz = 24'($random(seed)) | 24'h1;
	endfunction
	task cmp(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task step(input logic lz, input logic rz);
		@(posedge core_clk_i iff frame_start);
		cmp({28'h0, left_zero_flag_o, right_zero_flag_o, left_mute_o, right_mute_o},
			{28'h0, pins(cfg, zl == 1024, zr == 1024)});
		left_next <= lz ? 24'h0 : nz();
		right_next <= rz ? 24'h0 : nz();
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge core_clk_i);
		s_axi_awaddr_i <= a;
		s_axi_wdata_i <= d;
		s_axi_awvalid_i <= 1'h1;
		s_axi_wvalid_i <= 1'h1;
		s_axi_bready_i <= 1'h1;
		do begin
			@(posedge core_clk_i);
			if (s_axi_awready_o)
				s_axi_awvalid_i <= 1'h0;
			if (s_axi_wready_o)
				s_axi_wvalid_i <= 1'h0;
		end while ((s_axi_awvalid_i && !s_axi_awready_o) || (s_axi_wvalid_i && !s_axi_wready_o));
		while (!s_axi_bvalid_o)
			@(posedge core_clk_i);
		s_axi_bready_i <= 1'h0;
		cmp({30'h0, s_axi_bresp_o}, {30'h0, er});
		if (a == `AZD_OFS_CFG)
			cfg = d[3:0];
		repeat (3) @(posedge core_clk_i);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		@(posedge core_clk_i);
		s_axi_araddr_i <= a;
		s_axi_arvalid_i <= 1'h1;
		s_axi_rready_i <= 1'h1;
		do @(posedge core_clk_i); while (!s_axi_arready_o);
		s_axi_arvalid_i <= 1'h0;
		do @(posedge core_clk_i); while (!s_axi_rvalid_o);
		s_axi_rready_i <= 1'h0;
		cmp(s_axi_rdata_o, ed);
		cmp({30'h0, s_axi_rresp_o}, {30'h0, er});
	endtask
	task summarize;
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		seed = 32'hcb9f;
		{fails, n_tests, zl, zr, fc_q, cfg, arst_n_i} = '0;
		{left_next, right_next, s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} = '0;
		{s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i} = '0;
		s_axi_wstrb_i = 4'hf;
		repeat (8) @(posedge core_clk_i);
		arst_n_i <= 1'h1;
		rd(`AZD_OFS_CFG, 32'h0, `AZD_RESP_OKAY);
		rd(`AZD_OFS_MASK, 32'h0, `AZD_RESP_OKAY);
		rd(8'h40, 32'h0, `AZD_RESP_SLVERR);
		wr(8'h44, 32'h0, `AZD_RESP_SLVERR);
		$display("test reset done");
		repeat (1030) step(1'h1, 1'h1);
		rd(`AZD_OFS_STATUS, 32'h7, `AZD_RESP_OKAY);
		rd(`AZD_OFS_RUN, {5'h0, zr[10:0], 5'h0, zl[10:0]}, `AZD_RESP_OKAY);
		rd(`AZD_OFS_EVT, 32'h3, `AZD_RESP_OKAY);
		wr(`AZD_OFS_MASK, 32'h1, `AZD_RESP_OKAY);
		cmp({31'h0, irq_o}, 32'h1);
		wr(`AZD_OFS_EVT, 32'h1, `AZD_RESP_OKAY);
		rd(`AZD_OFS_EVT, 32'h2, `AZD_RESP_OKAY);
		cmp({31'h0, irq_o}, 32'h0);
		wr(`AZD_OFS_MASK, 32'h0, `AZD_RESP_OKAY);
		$display("test events done");
		for (int p = 0; p < 3; p++) begin
			for (int c = 0; c < 16; c += 2) begin
				wr(`AZD_OFS_CFG, 32'(c), `AZD_RESP_OKAY);
				step(p != 1, p != 2);
			end
			repeat (p == 1 ? 1030 : 3) step(p == 1, p != 1);
		end
		$display("test flags done");
		summarize();
	end
	initial begin
		repeat (40000) @(posedge core_clk_i);
		fails++;
		summarize();
	end
endmodule // azd_top_tb
`default_nettype wire
